/* File: src/spe_engine.sv */
// serial programming command engine behind the device uart
// Overview of operation
// [RULE1] erase whole array or 4-kbyte sectors to FFH
// [RULE2] protected: sector erase refused, chip erase unprotects
// [RULE3] password checked before erase/write/loader unless blank
// [RULE4] write data arrives as binary hex records
// [RULE5] end record: send flash sum C000H-FFFFH
// [RULE6] protected: write and loader modes refused
// [RULE7] loader: store records, send sum, jump
// [RULE8] sum mode returns flash sum, no read
// [RULE9] product code output is 13 bytes
// [RULE10] status output is 7 bytes, blank and protection
// [RULE11] protection setting blocks reads, write, loader
// [RULE12] 5AH matched and echoed, else silence
// [RULE13] bad baud byte: A1H A3H 62H, halt
// [RULE14] bad command: A1H A3H 63H, halt
// [RULE15] four password address bytes, no reply
// [RULE16] blank part: controller sends no password
// [RULE17] password mismatch or receive error halts
// [RULE18] area byte: start upper nibble, end lower
// [RULE19] checksum reply upper then lower byte
// [RULE20] after checksum wait for next command
// [RULE21] link 8N1, default 9600 bps
// [RULE22] valid baud byte applied after its echo
// [RULE23] command byte value set
// [RULE24] halted: ignore input, send nothing
module spe_engine #(
   parameter int       FLASH_BYTES = spe_pkg::FLASH_SIZE, // bytes summed from C000H
   parameter bit [6:0] BAUD_OK     = 7'h7F                // allowed rate codes
) (
   input  wire logic              REF_CLK,       // 20 MHz clock
   input  wire logic              SYS_RST,       // sync reset, active high
   input  wire spe_pkg::spe_rx_t  RX,            // received byte from uart
   output logic [7:0]             TX_DATA,       // byte to uart
   output logic                   TX_VALID,      // byte waiting
   input  wire logic              TX_READY,      // uart takes byte
   input  wire logic              TX_IDLE,       // uart shifter empty
   output logic [7:0]             BAUD_SEL,      // active rate code
   output logic                   BAUD_LD,       // pulse: apply BAUD_SEL
   input  wire logic              PROT_ACTIVE,   // stored read protection
   output logic [15:0]            FL_RADDR,      // flash read address
   input  wire logic [7:0]        FL_RDATA,      // flash data at FL_RADDR
   input  wire logic              FL_BUSY,       // flash program/erase busy
   output spe_pkg::spe_mem_t      MEM,           // flash or ram byte write
   output logic                   FL_ERASE,      // pulse: erase area
   output logic [7:0]             FL_ERASE_AREA, // start/end nibbles
   output logic                   PROT_SET,      // pulse: set protection
   output logic                   PROT_CLR,      // pulse: clear protection
   output logic                   RUN,           // pulse: start ram program
   output logic [15:0]            RUN_ADDR,      // ram start address
   output logic                   HALTED         // engine halted
);
   import spe_pkg::*;

   if (FLASH_BYTES < 1 || FLASH_BYTES > FLASH_SIZE) begin : g_chk
      $error("FLASH_BYTES out of range");
   end

   spe_st_t s, n;
   logic    push, pop;
   logic [7:0] pbyte, d;
   logic [1:0] bk;

   // ***********************
   // helpers
   // ***********************
   function automatic logic baud_ok(input logic [7:0] v);
      logic r;
      r = 1'b0;
      for (int i = 0; i < 7; i++) begin
         if (BAUD_OK[i] && v == BAUD_CODES[i]) r = 1'b1;
      end
      return r;
   endfunction : baud_ok

   function automatic logic cmd_ok(input logic [7:0] v);
      return v inside {CMD_ERASE, CMD_WRITE, CMD_RAM, CMD_SUM, CMD_ID, CMD_STAT, CMD_PROT};
   endfunction : cmd_ok

   function automatic logic [3:0] tx_len(input spe_kind_t k);
      unique case (k)
         K_ECHO:  return LEN_ECHO;
         K_ERR:   return LEN_ERR;
         K_SUM:   return LEN_SUM;
         K_ID:    return LEN_ID;
         default: return LEN_STAT;
      endcase
   endfunction : tx_len

   assign d        = RX.data;
   assign TX_VALID = s.bn != 2'h0;
   assign pop      = TX_VALID && TX_READY;
   assign HALTED   = s.st == S_HALT;

   // ***********************
   // next state
   // ***********************
   always_comb begin
      n          = s;
      push       = 1'b0;
      pbyte      = 8'h00;
      bk         = 2'h0;
      n.baud_ld  = 1'b0;
      n.mem.we   = 1'b0;
      n.erase    = 1'b0;
      n.prot_set = 1'b0;
      n.prot_clr = 1'b0;
      n.run      = 1'b0;
      n.rd_p     = 1'b0;
      unique case (s.st)
         S_IDLE: if (RX.vld && !RX.err && d == CMD_SETUP) begin // RULE12
            n.b   = d;
            n.knd = K_ECHO;
            n.idx = 16'h0000;
            n.nx  = S_BAUD;
            n.st  = S_SEND;
         end
         S_BAUD: if (RX.vld) begin
            n.b   = d;
            n.idx = 16'h0000;
            n.st  = S_SEND;
            n.knd = K_ECHO;
            n.nx  = S_BAUDW;
            if (RX.err || !baud_ok(d)) begin // RULE13
               n.knd  = K_ERR;
               n.code = ERR_BAUD;
               n.nx   = S_HALT;
            end
         end
         S_BAUDW: if (s.bn == 2'h0 && TX_IDLE) begin // RULE22
            n.baud    = s.b;
            n.baud_ld = 1'b1;
            n.st      = S_CMD;
         end
         S_CMD: if (RX.vld) begin
            n.cmd = d;
            n.b   = d;
            n.idx = 16'h0000;
            n.st  = S_SEND;
            n.knd = K_ECHO;
            n.nx  = S_POST;
            if (RX.err || !cmd_ok(d)) begin // RULE14 RULE23
               n.knd  = K_ERR;
               n.code = ERR_CMD;
               n.nx   = S_HALT;
            end
         end
         S_POST: begin
            n.idx   = 16'h0000;
            n.sum   = 16'h0000;
            n.blank = 1'b1;
            n.st    = S_CMD;
            unique case (s.cmd)
               CMD_ERASE: n.st = S_ADDR;
               CMD_WRITE, CMD_RAM: n.st = PROT_ACTIVE ? S_HALT : S_ADDR; // RULE6
               CMD_SUM: begin // RULE8
                  n.blk = 1'b0;
                  n.st  = S_SCAN;
               end
               CMD_ID: begin // RULE9
                  n.knd = K_ID;
                  n.nx  = S_CMD;
                  n.st  = S_SEND;
               end
               CMD_STAT: begin // RULE10
                  n.blk = 1'b1;
                  n.st  = S_SCAN;
               end
               default: n.prot_set = 1'b1; // RULE11
            endcase
         end
         S_SEND: if (s.bn != 2'h2) begin
            push  = 1'b1;
            n.idx = s.idx + 16'h0001;
            unique case (s.knd)
               K_ECHO: pbyte = s.b;
               K_ERR:  pbyte = s.idx < ERR_STEP ? ERR_PRE1 :
                               s.idx < 16'(2 * ERR_STEP) ? ERR_PRE2 : s.code; // RULE13 RULE14
               K_SUM:  pbyte = s.idx == 16'h0000 ? s.sum[15:8] : s.sum[7:0]; // RULE19
               K_ID:   pbyte = PROD_ID[4'(LEN_ID - 4'h1 - s.idx[3:0])];
               default: pbyte = s.idx == 16'h0000 ? {6'h00, PROT_ACTIVE, s.blank} : 8'h00;
            endcase
            if (s.idx[3:0] == tx_len(s.knd) - 4'h1) begin
               n.st  = s.nx;
               n.idx = 16'h0000;
            end
         end
         S_ADDR: if (RX.vld) begin // RULE15
            if (RX.err) n.st = S_HALT; // RULE17
            else begin
               if (s.idx < 16'h0002) n.a = {s.a[7:0], d};
               else n.pa = {s.pa[7:0], d};
               n.idx = s.idx + 16'h0001;
               if (s.idx == ADDR_LAST) begin
                  n.idx   = 16'h0000;
                  n.blk   = 1'b1;
                  n.blank = 1'b1;
                  n.st    = S_SCAN;
               end
            end
         end
         S_SCAN: if (!s.rd_p) begin
            n.raddr = (s.blk ? BLANK_BASE : FLASH_BASE) + s.idx; // RULE5 RULE8
            n.rd_p  = 1'b1;
         end else begin
            n.idx = s.idx + 16'h0001;
            if (s.blk) begin
               n.blank = s.blank && FL_RDATA == BYTE_ERASED;
               if (s.idx == BLANK_LAST) begin
                  n.idx = 16'h0000;
                  if (s.cmd == CMD_STAT) begin
                     n.knd = K_STAT;
                     n.nx  = S_CMD;
                     n.st  = S_SEND;
                  end else n.st = n.blank ? S_PWOK : S_PWCNT; // RULE3 RULE16
               end
            end else begin
               n.sum = s.sum + {8'h00, FL_RDATA};
               if (s.idx == 16'(FLASH_BYTES - 1)) begin
                  n.idx = 16'h0000;
                  n.knd = K_SUM;
                  n.nx  = S_CMD; // RULE20
                  n.st  = S_SEND;
               end
            end
         end
         S_PWCNT: if (!s.rd_p) begin
            n.raddr = s.a;
            n.rd_p  = 1'b1;
         end else begin
            n.cnt = FL_RDATA;
            n.idx = 16'h0000;
            n.st  = FL_RDATA == 8'h00 ? S_PWOK : S_PWSTR;
         end
         S_PWSTR: if (s.rd_p) begin
            n.idx = s.idx + 16'h0001;
            n.cnt = s.cnt - 8'h01;
            if (FL_RDATA != s.b) n.st = S_HALT; // RULE3 RULE17
            else if (s.cnt == 8'h01) n.st = S_PWOK;
         end else if (RX.vld) begin
            if (RX.err) n.st = S_HALT; // RULE17
            n.b     = d;
            n.raddr = s.pa + s.idx;
            n.rd_p  = !RX.err;
         end
         S_PWOK: begin
            n.ph    = PH_LEN;
            n.sum   = 16'h0000;
            n.first = 1'b1;
            n.st    = s.cmd == CMD_ERASE ? S_AREA : S_REC;
         end
         S_AREA: if (RX.vld) begin // RULE18
            if (RX.err || (PROT_ACTIVE && d != ERA_CHIP)) n.st = S_HALT; // RULE2
            else begin
               n.erase    = 1'b1; // RULE1
               n.area     = d;
               n.prot_clr = d == ERA_CHIP; // RULE2
               n.idx      = 16'h0000;
               n.st       = S_EWAIT;
            end
         end
         S_EWAIT: if (s.idx == 16'h0000) n.idx = 16'h0001;
         else if (!FL_BUSY) begin
            n.idx = 16'h0000;
            n.sum = 16'h0000;
            n.blk = 1'b0;
            n.st  = S_SCAN;
         end
         S_REC: if (RX.vld) begin // RULE4
            n.rck = s.rck + d;
            if (RX.err) n.st = S_HALT;
            else unique case (s.ph)
               PH_LEN: begin
                  n.rlen = d;
                  n.rck  = d;
                  n.ph   = PH_AHI;
               end
               PH_AHI: begin
                  n.a[15:8] = d;
                  n.ph      = PH_ALO;
               end
               PH_ALO: begin
                  n.a[7:0] = d;
                  n.ph     = PH_TYP;
               end
               PH_TYP: begin
                  n.rtyp = d;
                  n.cnt  = s.rlen;
                  n.ph   = s.rlen == 8'h00 ? PH_CKS : PH_DAT;
               end
               PH_DAT: begin
                  n.mem.we   = s.rtyp == REC_DATA;
                  n.mem.ram  = s.cmd == CMD_RAM;
                  n.mem.addr = s.a;
                  n.mem.data = d;
                  n.a        = s.a + 16'h0001;
                  n.cnt      = s.cnt - 8'h01;
                  if (s.cmd == CMD_RAM) n.sum = s.sum + {8'h00, d}; // RULE7
                  if (s.first && s.rtyp == REC_DATA) begin
                     n.run_a = s.a;
                     n.first = 1'b0;
                  end
                  if (s.cnt == 8'h01) n.ph = PH_CKS;
               end
               default: begin
                  n.ph = PH_LEN;
                  if (n.rck != 8'h00) n.st = S_HALT;
                  else if (s.rtyp == REC_END) begin
                     n.idx = 16'h0000;
                     if (s.cmd == CMD_WRITE) begin // RULE5
                        n.sum = 16'h0000;
                        n.blk = 1'b0;
                        n.st  = S_SCAN;
                     end else begin // RULE7
                        n.knd = K_SUM;
                        n.nx  = S_RUN;
                        n.st  = S_SEND;
                     end
                  end
               end
            endcase
         end
         S_RUN: if (s.bn == 2'h0) begin // RULE7
            n.run = 1'b1;
            n.st  = S_EXEC;
         end
         S_EXEC, S_HALT: ; // RULE24
         default: n.st = S_HALT;
      endcase
      // two-entry transmit buffer
      bk = s.bn - {1'b0, pop};
      if (pop) begin
         n.bd[0] = s.bd[1];
      end
      if (push) begin
         n.bd[bk[0]] = pbyte;
      end
      n.bn = bk + {1'b0, push};
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         s      <= '0;
         s.st   <= S_IDLE;
         s.nx   <= S_IDLE;
         s.baud <= BAUD_DEF; // RULE21
      end else begin
         s <= n;
      end
   end

   assign TX_DATA       = s.bd[0];
   assign BAUD_SEL      = s.baud;
   assign BAUD_LD       = s.baud_ld;
   assign FL_RADDR      = s.raddr;
   assign MEM           = s.mem;
   assign FL_ERASE      = s.erase;
   assign FL_ERASE_AREA = s.area;
   assign PROT_SET      = s.prot_set;
   assign PROT_CLR      = s.prot_clr;
   assign RUN           = s.run;
   assign RUN_ADDR      = s.run_a;

   // ***********************
   // checks
   // ***********************
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);

   halt_quiet_a: assert property (HALTED |=> HALTED && !MEM.we && !FL_ERASE && !BAUD_LD) // RULE24
      else $error("halted engine acted");
   match_echo_a: assert property (s.st == S_IDLE && RX.vld && !RX.err && d == CMD_SETUP
      |-> ##[1:4] (TX_VALID && TX_DATA == CMD_SETUP)) // RULE12
      else $error("match byte not echoed");
   no_match_a: assert property (s.st == S_IDLE && RX.vld && d != CMD_SETUP |=> s.st == S_IDLE)
      else $error("unmatched byte left idle"); // RULE12
   baud_apply_a: assert property (BAUD_LD |-> !TX_VALID && TX_IDLE && $past(s.st) == S_BAUDW)
      else $error("baud applied before echo done"); // RULE22
   sector_prot_a: assert property (s.st == S_AREA && RX.vld && PROT_ACTIVE && d != ERA_CHIP
      |=> HALTED && !FL_ERASE) // RULE2
      else $error("sector erase while protected");
   chip_clr_a: assert property (FL_ERASE && FL_ERASE_AREA == ERA_CHIP |-> PROT_CLR) // RULE2
      else $error("chip erase kept protection");
   bad_cmd_a: assert property (s.st == S_CMD && RX.vld && !cmd_ok(d)
      |=> s.knd == K_ERR && s.code == ERR_CMD && s.nx == S_HALT) // RULE14
      else $error("bad command not refused");
   pw_err_a: assert property ((s.st == S_ADDR || s.st == S_PWSTR) && RX.vld && RX.err
      |=> HALTED) // RULE17
      else $error("receive error did not halt");
   prot_write_a: assert property (s.st == S_POST && PROT_ACTIVE
      && (s.cmd == CMD_WRITE || s.cmd == CMD_RAM) |=> HALTED) // RULE6
      else $error("protected write entered");
   sum_range_a: assert property (s.st == S_SCAN && !s.blk && s.rd_p |-> FL_RADDR >= FLASH_BASE)
      else $error("sum outside flash"); // RULE8

   cov_echo_c:  cover property (BAUD_LD ##[1:300] (s.st == S_POST));
   cov_erase_c: cover property (FL_ERASE ##[1:100] (s.st == S_SEND && s.knd == K_SUM));
   cov_run_c:   cover property (RUN);
   cov_halt_c:  cover property (s.knd == K_ERR ##1 HALTED);
endmodule : spe_engine

/* File: src/spe_pkg.sv */
// constants, carriers and state types of the serial programming command engine
package spe_pkg;
   // ***********************
   // command and reply codes
   // ***********************
   localparam logic [7:0] CMD_SETUP   = 8'h5A;
   localparam logic [7:0] CMD_ERASE   = 8'hF0;
   localparam logic [7:0] CMD_WRITE   = 8'h30;
   localparam logic [7:0] CMD_RAM     = 8'h60;
   localparam logic [7:0] CMD_SUM     = 8'h90;
   localparam logic [7:0] CMD_ID      = 8'hC0;
   localparam logic [7:0] CMD_STAT    = 8'hC3;
   localparam logic [7:0] CMD_PROT    = 8'hFA;
   localparam logic [7:0] ERR_PRE1    = 8'hA1;
   localparam logic [7:0] ERR_PRE2    = 8'hA3;
   localparam logic [7:0] ERR_BAUD    = 8'h62;
   localparam logic [7:0] ERR_CMD     = 8'h63;
   localparam logic [7:0] BAUD_DEF    = 8'h28;
   localparam logic [7:0] ERA_CHIP    = 8'hCF;
   localparam logic [7:0] BYTE_ERASED = 8'hFF;
   localparam logic [7:0] REC_DATA    = 8'h00;
   localparam logic [7:0] REC_END     = 8'h01;
   localparam logic [6:0][7:0] BAUD_CODES = {8'h28, 8'h18, 8'h0A, 8'h07, 8'h06, 8'h05, 8'h04};
   // id value is arbitrary apart from the area bytes C000..FFFF
   localparam logic [12:0][7:0] PROD_ID = {8'hFF, 8'hFF, 8'h00, 8'hC0, 8'h00, 8'h00, 8'h00,
                                           8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
   // ***********************
   // address ranges and lengths
   // ***********************
   localparam logic [15:0] FLASH_BASE  = 16'hC000;
   localparam logic [15:0] BLANK_BASE  = 16'hFFE0;
   localparam int          FLASH_SIZE  = 16384;
   localparam logic [15:0] BLANK_LAST  = 16'h001F;
   localparam logic [15:0] ADDR_LAST   = 16'h0003;
   localparam logic [15:0] ERR_STEP    = 16'h0003;
   localparam logic [3:0]  LEN_ECHO    = 4'h1;
   localparam logic [3:0]  LEN_ERR     = 4'h9;
   localparam logic [3:0]  LEN_SUM     = 4'h2;
   localparam logic [3:0]  LEN_ID      = 4'hD;
   localparam logic [3:0]  LEN_STAT    = 4'h7;
   localparam logic [2:0]  PH_LEN      = 3'h0;
   localparam logic [2:0]  PH_AHI      = 3'h1;
   localparam logic [2:0]  PH_ALO      = 3'h2;
   localparam logic [2:0]  PH_TYP      = 3'h3;
   localparam logic [2:0]  PH_DAT      = 3'h4;
   localparam logic [2:0]  PH_CKS      = 3'h5;
   // ***********************
   // types
   // ***********************
   typedef enum logic [4:0] {
      S_IDLE = 5'h00, S_BAUD = 5'h01, S_BAUDW = 5'h02, S_CMD  = 5'h03, S_POST = 5'h04,
      S_SEND = 5'h05, S_ADDR = 5'h06, S_SCAN  = 5'h07, S_PWCNT = 5'h08, S_PWSTR = 5'h09,
      S_PWOK = 5'h0A, S_AREA = 5'h0B, S_EWAIT = 5'h0C, S_REC  = 5'h0D, S_RUN  = 5'h0E,
      S_EXEC = 5'h0F, S_HALT = 5'h10
   } spe_state_t;
   typedef enum logic [2:0] {
      K_ECHO = 3'h0, K_ERR = 3'h1, K_SUM = 3'h2, K_ID = 3'h3, K_STAT = 3'h4
   } spe_kind_t;
   typedef struct packed {
      logic       vld;
      logic       err;
      logic [7:0] data;
   } spe_rx_t;
   typedef struct packed {
      logic        we;
      logic        ram;
      logic [15:0] addr;
      logic [7:0]  data;
   } spe_mem_t;
   typedef struct packed {
      spe_state_t      st;
      spe_state_t      nx;
      spe_kind_t       knd;
      logic [7:0]      cmd;
      logic [7:0]      b;
      logic [7:0]      code;
      logic [15:0]     a;
      logic [15:0]     pa;
      logic [15:0]     idx;
      logic [7:0]      cnt;
      logic [15:0]     sum;
      logic            blk;
      logic            blank;
      logic            rd_p;
      logic [2:0]      ph;
      logic [7:0]      rlen;
      logic [7:0]      rtyp;
      logic [7:0]      rck;
      logic            first;
      logic [15:0]     run_a;
      logic [15:0]     raddr;
      logic [7:0]      baud;
      logic            baud_ld;
      spe_mem_t        mem;
      logic            erase;
      logic [7:0]      area;
      logic            prot_set;
      logic            prot_clr;
      logic            run;
      logic [1:0][7:0] bd;
      logic [1:0]      bn;
   } spe_st_t;
endpackage : spe_pkg

/* File: bench/spe_host_model.sv */
// flash array, protection store and uart transmitter beside the engine
module spe_host_model (
   input  wire logic              clk,          // engine clock
   input  wire logic              tx_valid,     // engine byte waiting
   output logic                   tx_ready,     // byte taken this edge
   output logic                   tx_idle,      // shifter empty
   input  wire logic [15:0]       fl_raddr,     // flash read address
   output logic [7:0]             fl_rdata,     // flash read data
   output logic                   fl_busy,      // erase in progress
   input  wire spe_pkg::spe_mem_t mem,          // byte write
   input  wire logic              fl_erase,     // erase pulse
   input  wire logic [7:0]        fl_erase_area, // start and end sector
   input  wire logic              prot_set,     // protection on
   input  wire logic              prot_clr,     // protection off
   output logic                   prot_active   // stored protection
);
   import spe_pkg::*;
   logic [7:0] flash [0:65535];
   logic [2:0] sh_q;
   logic [3:0] busy_q;
   logic       prot_q;
   assign fl_rdata    = flash[fl_raddr];
   assign fl_busy     = busy_q != 4'h0;
   assign tx_idle     = sh_q == 3'h0;
   assign prot_active = prot_q;
   initial begin
      sh_q = 3'h0;
      busy_q = 4'h0;
      prot_q = 1'b0;
      tx_ready = 1'b0;
      for (int i = 0; i < 65536; i++) flash[i] = 8'h00;
   end
   // *****************
   // shifter and random stalls
   // *****************
   always @(posedge clk) begin
      if (tx_valid && tx_ready) sh_q <= 3'h4;
      else if (sh_q != 3'h0) sh_q <= sh_q - 3'h1;
      #2;
      tx_ready = (sh_q == 3'h0) && ($urandom_range(3) != 0);
   end
   // *****************
   // flash and protection
   // *****************
   always @(posedge clk) begin
      if (mem.we && !mem.ram) flash[mem.addr] <= mem.data;
      if (fl_erase) begin
         busy_q <= 4'hA;
         for (int a = int'(fl_erase_area[7:4]) * 4096;
              a < (int'(fl_erase_area[3:0]) + 1) * 4096; a++) flash[a] = BYTE_ERASED;
      end else if (busy_q != 4'h0) busy_q <= busy_q - 4'h1;
      if (prot_clr) prot_q <= 1'b0;
      else if (prot_set) prot_q <= 1'b1;
   end
endmodule : spe_host_model

/* File: bench/serial_prom_mode_command_engine_tb.sv */
// self-checking bench of the serial programming command engine
module serial_prom_mode_command_engine_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import spe_pkg::*;
   localparam int FB = 16;
   // loader image: 5AH at 0050H, then end record
   localparam logic [7:0] LDR [11] = '{8'h01, 8'h00, 8'h50, 8'h00, 8'h5A, 8'h55,
                                       8'h00, 8'h00, 8'h00, 8'h01, 8'hFF};
   logic        ref_clk, sys_rst, tx_valid, tx_ready, tx_idle, baud_ld, prot_active;
   logic        fl_busy, fl_erase, prot_set, prot_clr, run, halted;
   logic [7:0]  tx_data, baud_sel, fl_rdata, fl_erase_area;
   logic [15:0] fl_raddr, run_addr;
   spe_rx_t     rx;
   spe_mem_t    mem;
   logic [7:0]  exp_q [$];
   int          miscompares, n_compared, cycles;
   spe_engine #(.FLASH_BYTES(FB)) u_spe_engine (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .RX(rx),
      .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_IDLE(tx_idle),
      .BAUD_SEL(baud_sel), .BAUD_LD(baud_ld), .PROT_ACTIVE(prot_active), .FL_RADDR(fl_raddr),
      .FL_RDATA(fl_rdata), .FL_BUSY(fl_busy), .MEM(mem), .FL_ERASE(fl_erase),
      .FL_ERASE_AREA(fl_erase_area), .PROT_SET(prot_set), .PROT_CLR(prot_clr), .RUN(run),
      .RUN_ADDR(run_addr), .HALTED(halted));
   spe_host_model u_spe_host_model (.clk(ref_clk), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_idle(tx_idle), .fl_raddr(fl_raddr), .fl_rdata(fl_rdata), .fl_busy(fl_busy),
      .mem(mem), .fl_erase(fl_erase), .fl_erase_area(fl_erase_area), .prot_set(prot_set),
      .prot_clr(prot_clr), .prot_active(prot_active));
   always #25 ref_clk = ~ref_clk;
   // *****************
   // compare and report
   // *****************
   task automatic check8(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : check8
   task automatic check1(input string nm, input logic e, input logic g);
      check8(nm, {7'h00, e}, {7'h00, g});
   endtask : check1
   task automatic final_report();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         final_report();
      end
      if (!sys_rst && tx_valid && tx_ready) begin
         if (exp_q.size() == 0) check8("tx_data", 8'h00, 8'hxx);
         else check8("tx_data", exp_q.pop_front(), tx_data);
      end
   end
   // *****************
   // link tasks
   // *****************
   task automatic send(input logic [7:0] b);
      repeat (80) @(posedge ref_clk);
      #2 rx = '{vld: 1'b1, err: rx.err, data: b};
      @(posedge ref_clk);
      #2 rx.vld = 1'b0;
   endtask : send
   task automatic drain();
      int n;
      n = 0;
      while ((exp_q.size() != 0 || tx_valid !== 1'b0) && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      repeat (100) @(posedge ref_clk);
      if (exp_q.size() != 0) check8("reply count", 8'h00, 8'(exp_q.size()));
      exp_q.delete();
   endtask : drain
   task automatic cmd(input logic [7:0] c);
      exp_q.push_back(c);
      send(c);
   endtask : cmd
   task automatic link(input logic [7:0] bd);
      send(8'h33);
      cmd(CMD_SETUP);
      cmd(bd);
      drain();
      check8("baud_sel", bd, baud_sel);
   endtask : link
   task automatic put_sum();
      logic [15:0] s;
      s = 16'h0000;
      for (int i = 0; i < FB; i++) s += 16'(u_spe_host_model.flash[16'hC000 + i]);
      exp_q.push_back(s[15:8]);
      exp_q.push_back(s[7:0]);
   endtask : put_sum
   task automatic put_err(input logic [7:0] code);
      for (int i = 0; i < 9; i++) exp_q.push_back(i < 3 ? ERR_PRE1 : i < 6 ? ERR_PRE2 : code);
   endtask : put_err
   task automatic pw_head(input logic [7:0] p0, input logic [7:0] p1, input bit pw);
      send(8'hFF);
      send(8'hE1);
      send(8'hFF);
      send(8'hE2);
      if (pw) begin
         send(p0);
         send(p1);
      end
   endtask : pw_head
   task automatic status(input logic [7:0] b0);
      cmd(CMD_STAT);
      exp_q.push_back(b0);
      repeat (6) exp_q.push_back(8'h00);
      drain();
   endtask : status
   task automatic stop_check();
      drain();
      send(CMD_SETUP);
      drain();
      check1("halted", 1'b1, halted);
   endtask : stop_check
   task automatic rst();
      #2 sys_rst = 1'b1;
      repeat (2) @(posedge ref_clk);
      #2 sys_rst = 1'b0;
   endtask : rst
   // *****************
   // main sequence
   // *****************
   initial begin
      void'($urandom(61));
      ref_clk = 1'b0;
      sys_rst = 1'b1;
      rx = '0;
      miscompares = 0;
      n_compared = 0;
      cycles = 0;
      repeat (16) @(posedge ref_clk);
      for (int i = 0; i < FB; i++) u_spe_host_model.flash[16'hC000 + i] = 8'(i * 7 + 3);
      u_spe_host_model.flash[16'hFFE1] = 8'h02;
      u_spe_host_model.flash[16'hFFE2] = 8'h3C;
      u_spe_host_model.flash[16'hFFE3] = 8'hC3;
      #2 sys_rst = 1'b0;
      check8("baud_sel", BAUD_DEF, baud_sel);
      link(8'h0A);
      cmd(CMD_SUM);
      put_sum();
      drain();
      cmd(CMD_ID);
      for (int i = 0; i < 13; i++) exp_q.push_back(PROD_ID[12 - i]);
      drain();
      status(8'h00);
      cmd(CMD_PROT);
      drain();
      status(8'h02);
      cmd(CMD_ERASE);
      pw_head(8'h3C, 8'hC3, 1'b1);
      exp_q.push_back(8'h0F);
      exp_q.push_back(8'hF0);
      send(ERA_CHIP);
      drain();
      check1("prot", 1'b0, prot_active);
      status(8'h01);
      cmd(CMD_WRITE);
      pw_head(8'h00, 8'h00, 1'b0);
      send(8'h01);
      send(8'hC0);
      send(8'h00);
      send(REC_DATA);
      send(8'h5A);
      send(8'hE5);
      exp_q.push_back(8'h0F);
      exp_q.push_back(8'h4B);
      send(8'h00);
      send(8'h00);
      send(8'h00);
      send(REC_END);
      send(8'hFF);
      drain();
      cmd(CMD_RAM);
      pw_head(8'h00, 8'h00, 1'b0);
      foreach (LDR[i]) send(LDR[i]);
      exp_q.push_back(8'h00);
      exp_q.push_back(8'h5A);
      drain();
      check8("run_addr", 8'h50, run_addr[7:0]);
      rst();
      link(BAUD_DEF);
      cmd(CMD_PROT);
      drain();
      cmd(CMD_WRITE);
      stop_check();
      rst();
      cmd(CMD_SETUP);
      put_err(ERR_BAUD);
      send(8'h99);
      stop_check();
      rst();
      link(BAUD_DEF);
      put_err(ERR_CMD);
      send(8'h77);
      stop_check();
      rst();
      link(BAUD_DEF);
      cmd(CMD_ERASE);
      pw_head(8'h00, 8'h00, 1'b0);
      send(8'hCC);
      stop_check();
      u_spe_host_model.flash[16'hFFE0] = 8'h00;
      rst();
      link(BAUD_DEF);
      cmd(CMD_ERASE);
      pw_head(8'h3C, 8'h00, 1'b1);
      stop_check();
      rst();
      link(BAUD_DEF);
      cmd(CMD_ERASE);
      rx.err = 1'b1;
      send(8'hFF);
      stop_check();
      final_report();
   end
endmodule : serial_prom_mode_command_engine_tb
